// ===== core/ods_defines.svh
`ifndef ODS_DEFINES_SVH
`define ODS_DEFINES_SVH

// ------------------------------------------------------------
// Channel count and widths
// ------------------------------------------------------------
`define ODS_NCH        8
`define ODS_MSB        7
`define ODS_ALL_OFF    8'h00
`define ODS_ALL_ON     8'hFF

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define ODS_CLK_MHZ    20
`define ODS_BLANK_NS   10000
`define ODS_BLANK_W    8
`define ODS_BLANK_CYC  ((`ODS_BLANK_NS * `ODS_CLK_MHZ + 999) / 1000)
`define ODS_BLANK_ZERO 8'h00
`define ODS_BLANK_ONE  8'h01

`endif

// ===== core/ods_pkg.sv
`include "ods_defines.svh"

package ods_pkg;

   // ------------------------------------------------------------
   // Pin samples taken from outside the system clock domain
   // ------------------------------------------------------------
   typedef struct packed {
      logic                load_enable;
      logic                standby_n;
      logic [`ODS_MSB:0]   above_ref;
      logic                overtemp;
      logic                emergency;
      logic [`ODS_MSB:0]   local_dissip;
      logic                overvolt;
   } ods_pins_t;

   // ------------------------------------------------------------
   // Core state, system clock domain
   // ------------------------------------------------------------
   typedef struct packed {
      ods_pins_t                 sync1;
      ods_pins_t                 sync2;
      logic                      le_prev;
      logic [`ODS_MSB:0]         latch;
      logic [`ODS_MSB:0]         drive;
      logic                      emerg_hold;
      logic [`ODS_BLANK_W-1:0]   blank_cnt;
      logic [`ODS_MSB:0]         snap;
      logic                      short_flag_n;
      logic                      open_flag_n;
   } ods_core_st_t;

   // ------------------------------------------------------------
   // Link state, serial clock domain
   // ------------------------------------------------------------
   typedef struct packed {
      logic [`ODS_MSB:0]   shreg;
   } ods_link_st_t;

   typedef struct packed {
      logic                oe;
      logic                lvl;
   } ods_so_st_t;

endpackage

// ===== core/ods_link_if.sv
`timescale 1ns/100ps
`include "ods_defines.svh"

interface ods_link_if;
   logic [`ODS_MSB:0]   shreg;
   logic [`ODS_MSB:0]   status;

   modport core (
      input  shreg,
      output status
   );

   modport link (
      output shreg,
      input  status
   );
endinterface : ods_link_if

// ===== core/ods_link_shifter.sv
`timescale 1ns/100ps
`include "ods_defines.svh"

module ods_link_shifter (
   // Serial pins
   input  wire logic    serial_clk_in,
   input  wire logic    serial_in,
   input  wire logic    load_enable_in,
   // Core side
   ods_link_if.link     lk,
   // Open-collector serial output
   output logic         so_lvl_out,
   output logic         so_oe_out
);

   ods_pkg::ods_link_st_t   st_q;
   ods_pkg::ods_link_st_t   st_d;
   ods_pkg::ods_so_st_t     so_q;
   ods_pkg::ods_so_st_t     so_d;
   logic                    started_q;
   logic [`ODS_MSB:0]       view;

   // ------------------------------------------------------------
   // Shift path
   // ------------------------------------------------------------
   // Status byte stays frozen in the core during a frame, so the first
   // shift of a frame takes it instead of the old register contents.
   always_comb begin
      view  = started_q ? st_q.shreg : lk.status;
      st_d  = st_q;
      so_d  = so_q;
      if (!load_enable_in) begin
         st_d.shreg = {serial_in, view[`ODS_MSB:1]};
      end
      // Channel 1 leaves first, so the last bit shifted in lands on channel 8.
      so_d.oe  = ~view[0];
      so_d.lvl = 1'b0;
   end

   always_ff @(negedge serial_clk_in) begin
      st_q <= st_d;
   end

   // Frame start is ended by the frame's own signal, not a clock edge.
   always_ff @(negedge serial_clk_in or posedge load_enable_in) begin
      if (load_enable_in) begin
         started_q <= 1'b0;
      end else begin
         started_q <= 1'b1;
      end
   end

   always_ff @(posedge serial_clk_in or posedge load_enable_in) begin
      if (load_enable_in) begin
         so_q <= '0;
      end else begin
         so_q <= so_d;
      end
   end

   assign lk.shreg   = st_q.shreg;
   assign so_lvl_out = so_q.lvl;
   assign so_oe_out  = so_q.oe;

endmodule // ods_link_shifter

// ===== core/ods_driver_core.sv
// Behaviour
// - eight-bit shift register feeds an eight-bit latch driving the eight stages.
// - while load enable low, serial input shifts in on serial clock falling edge.
// - while load enable low, register contents shift out on serial clock rising edge.
// - control bit one turns its driver on, zero turns it off.
// - load enable rising edge copies the shift register into the latch on the third enabled system clock edge after it.
// - load enable high ignores serial pins and releases the serial output high.
// - short when on and output above reference; open when off and below.
// - a fault pulls its flag low and inverts that channel's status bit.
// - each flag asserts when its fault exists on any of the eight stages.
// - load enable falling edge loads the eight-channel status into the register.
// - shorted load is current limited and pulls the short flag low.
// - first-stage overtemperature forces off only shorted outputs; status unchanged.
// - emergency temperature turns all off until below first-stage threshold.
// - any local dissipation excess forces off every shorted output.
// - supply overvoltage forces off shorted outputs until the condition ends.
// - short flag is blanked for a delay after each latch update.
// - devices daisy-chain serial out to serial in, sharing clock and enable.
// - power-up or standby forces all drivers off; standby acts as reset.

`timescale 1ns/100ps
`include "ods_defines.svh"

module ods_driver_core (
   // System clock and control
   input  wire logic                 clk_sys_in,
   input  wire logic                 sys_rst_in,
   input  wire logic                 clk_en_in,

   // Serial link
   input  wire logic                 serial_clk_in,
   input  wire logic                 serial_in,
   input  wire logic                 load_enable_in,
   output logic                      serial_out_out,
   output logic                      serial_out_oe_out,

   // Standby
   input  wire logic                 standby_n_in,

   // Analog sensing
   input  wire logic [`ODS_MSB:0]    out_above_ref_in,
   input  wire logic                 overtemp_in,
   input  wire logic                 emergency_temp_in,
   input  wire logic [`ODS_MSB:0]    local_dissip_in,
   input  wire logic                 supply_overvoltage_threshold_in,

   // Power stages and fault flags
   output logic [`ODS_MSB:0]         driver_output_out,
   output logic                      short_fault_flag_n_out,
   output logic                      open_load_flag_n_out
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   ods_pkg::ods_core_st_t    st_q;
   ods_pkg::ods_core_st_t    st_d;
   ods_pkg::ods_pins_t       pins;
   logic [`ODS_MSB:0]        short_det;
   logic [`ODS_MSB:0]        open_det;
   logic [`ODS_MSB:0]        status_word;
   logic [`ODS_MSB:0]        cut_mask;
   logic                     le_rise;
   logic                     shorted_cut;
   logic                     so_lvl;
   logic                     so_oe;

   ods_link_if               lk ();

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Comparator decode shared by both fault kinds.
   function automatic logic [`ODS_MSB:0] fault_vec(
      input logic [`ODS_MSB:0] ctrl,
      input logic [`ODS_MSB:0] above,
      input logic              want_short
   );
      logic [`ODS_MSB:0] r;
      r = `ODS_ALL_OFF;
      if (want_short) begin
         r = ctrl & above;
      end else begin
         r = ~ctrl & ~above;
      end
      return r;
   endfunction

   function automatic logic any_set(input logic [`ODS_MSB:0] v);
      return |v;
   endfunction

   // ------------------------------------------------------------
   // Link domain
   // ------------------------------------------------------------
   // The serial output is open collector: the pin is only ever pulled low.
   ods_link_shifter u_link (
      .serial_clk_in  (serial_clk_in),
      .serial_in      (serial_in),
      .load_enable_in (load_enable_in),
      .lk             (lk.link),
      .so_lvl_out     (so_lvl),
      .so_oe_out      (so_oe)
   );

   // ------------------------------------------------------------
   // Pin gathering
   // ------------------------------------------------------------
   always_comb begin
      pins.load_enable  = load_enable_in;
      pins.standby_n    = standby_n_in;
      pins.above_ref    = out_above_ref_in;
      pins.overtemp     = overtemp_in;
      pins.emergency    = emergency_temp_in;
      pins.local_dissip = local_dissip_in;
      pins.overvolt     = supply_overvoltage_threshold_in;
   end

   // ------------------------------------------------------------
   // Fault decode
   // ------------------------------------------------------------
   // Faults are judged against the control latch, not the forced-off
   // drive, so protection never alters what diagnostics report.
   always_comb begin
      short_det   = fault_vec(st_q.latch, st_q.sync2.above_ref, 1'b1);
      open_det    = fault_vec(st_q.latch, st_q.sync2.above_ref, 1'b0);
      status_word = st_q.latch ^ (short_det | open_det);
      le_rise     = st_q.sync2.load_enable & ~st_q.le_prev;
      shorted_cut = st_q.sync2.overtemp
                  | any_set(st_q.sync2.local_dissip)
                  | st_q.sync2.overvolt;
      cut_mask    = shorted_cut ? short_det : `ODS_ALL_OFF;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;

      // Two-stage synchronisers; the first stage feeds only the second.
      st_d.sync1   = pins;
      st_d.sync2   = st_q.sync1;
      st_d.le_prev = st_q.sync2.load_enable;

      // The shift register cannot move while load enable is high, so the
      // word is stable by the time the synchronised rise is seen here.
      if (le_rise) begin
         st_d.latch     = lk.shreg;
         st_d.blank_cnt = `ODS_BLANK_W'(`ODS_BLANK_CYC);
      end else if (st_q.blank_cnt != `ODS_BLANK_ZERO) begin
         st_d.blank_cnt = st_q.blank_cnt - `ODS_BLANK_ONE;
      end

      // Emergency shutdown holds until the first-stage level clears.
      if (st_q.sync2.emergency) begin
         st_d.emerg_hold = 1'b1;
      end else if (!st_q.sync2.overtemp) begin
         st_d.emerg_hold = 1'b0;
      end

      if (st_q.emerg_hold || st_q.sync2.emergency) begin
         st_d.drive = `ODS_ALL_OFF;
      end else begin
         st_d.drive = st_q.latch & ~cut_mask;
      end

      // Snapshot tracks live status while the link is idle and freezes
      // for the whole frame, which makes it safe to read from the link.
      if (st_q.sync2.load_enable) begin
         st_d.snap = status_word;
      end

      st_d.short_flag_n = ~any_set(short_det)
                        | (st_q.blank_cnt != `ODS_BLANK_ZERO);
      st_d.open_flag_n  = ~any_set(open_det);

      if (!st_q.sync2.standby_n) begin
         st_d.latch      = `ODS_ALL_OFF;
         st_d.drive      = `ODS_ALL_OFF;
         st_d.emerg_hold = 1'b0;
         st_d.blank_cnt  = `ODS_BLANK_ZERO;
      end

      if (sys_rst_in) begin
         st_d              = '0;
         st_d.short_flag_n = 1'b1;
         st_d.open_flag_n  = 1'b1;
         // Load enable idles high; clearing it to zero would fake a rise.
         st_d.sync1.load_enable = 1'b1;
         st_d.sync2.load_enable = 1'b1;
         st_d.le_prev           = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (clk_en_in || sys_rst_in) begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign lk.status              = st_q.snap;
   assign driver_output_out      = st_q.drive;
   assign short_fault_flag_n_out = st_q.short_flag_n;
   assign open_load_flag_n_out   = st_q.open_flag_n;
   assign serial_out_out         = so_lvl;
   assign serial_out_oe_out      = so_oe;

endmodule // ods_driver_core

// ===== dv/ods_core_asserts.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checker for the driver core
// ------------------------------------------------------------
module ods_core_asserts (
   // Clocks, reset and serial pins
   input wire logic       clk_sys_in, sys_rst_in, clk_en_in,
   input wire logic       serial_clk_in, serial_in, load_enable_in,
   input wire logic       serial_out_out, serial_out_oe_out, standby_n_in,
   // Sensing
   input wire logic [7:0] out_above_ref_in, local_dissip_in,
   input wire logic       overtemp_in, emergency_temp_in,
   input wire logic       supply_overvoltage_threshold_in,
   // Stages and flags
   input wire logic [7:0] driver_output_out,
   input wire logic       short_fault_flag_n_out, open_load_flag_n_out
);
   logic       le_q;
   logic [7:0] since_q;
   // Cycles since load enable rose, saturating so old updates stay quiet
   always_ff @(posedge clk_sys_in) begin
      le_q <= load_enable_in;
      if (sys_rst_in) since_q <= 8'hFF;
      else if (load_enable_in && !le_q) since_q <= 8'h00;
      else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   a_reset_clear:
   assert property (disable iff (1'b0) sys_rst_in |=> driver_output_out == 8'h00
      && short_fault_flag_n_out && open_load_flag_n_out) else $error("reset state wrong");
   a_so_released:
   assert property (load_enable_in |-> !serial_out_oe_out) else $error("serial out held");
   a_emerg_off:
   assert property (emergency_temp_in [*5] |-> driver_output_out == 8'h00)
      else $error("stages on in emergency");
   a_short_blanked:
   assert property (since_q > 8'h05 && since_q < 8'hC0 |-> short_fault_flag_n_out)
      else $error("short flag not blanked");
   a_short_set:
   assert property (((driver_output_out & out_above_ref_in) != 8'h00 && since_q == 8'hFF) [*5]
      |-> !short_fault_flag_n_out) else $error("short flag missing");
   a_short_clear:
   assert property ((out_above_ref_in == 8'h00) [*5] |-> short_fault_flag_n_out)
      else $error("false short flag");
   a_open_set:
   assert property ((out_above_ref_in == 8'h00 && driver_output_out != 8'hFF
      && !emergency_temp_in && !overtemp_in) [*5] |-> !open_load_flag_n_out)
      else $error("open flag missing");
   a_otemp_cut:
   assert property ((overtemp_in && $stable(out_above_ref_in)) [*5]
      |-> (driver_output_out & out_above_ref_in) == 8'h00) else $error("otemp cut");
   a_dissip_cut:
   assert property ((|local_dissip_in && $stable(out_above_ref_in)) [*5]
      |-> (driver_output_out & out_above_ref_in) == 8'h00) else $error("dissip cut");
   a_ovolt_cut:
   assert property ((supply_overvoltage_threshold_in && $stable(out_above_ref_in)) [*5]
      |-> (driver_output_out & out_above_ref_in) == 8'h00) else $error("ovolt cut");
   a_standby_off:
   assert property ((!standby_n_in) [*5] |-> driver_output_out == 8'h00)
      else $error("stages on in standby");
endmodule // ods_core_asserts
bind ods_driver_core ods_core_asserts u_chk (.*);

// ===== dv/ods_host_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host side of the three-wire link, 48 ns serial clock
// ------------------------------------------------------------
module ods_host_model (
   // Serial pins towards the driver
   output logic      serial_clk_out,
   output logic      serial_data_out,
   output logic      load_enable_out,
   // Open-collector return, pulled up
   input  wire logic serial_ret_in
);
   initial begin
      serial_clk_out = 1'b0;
      serial_data_out = 1'b0;
      load_enable_out = 1'b0;
      // A clean rise clears the serial output flops, which have no reset
      #1;
      load_enable_out = 1'b1;
   end
   // Clock stands still outside frames, except in idle_clocks
   task automatic xfer(input logic [7:0] ctrl, output logic [7:0] st);
      load_enable_out = 1'b0;
      #250; // Status snapshot needs time to settle
      for (int i = 0; i < 8; i++) begin
         serial_clk_out = 1'b1;
         serial_data_out = ctrl[i];
         #24;
         st[i] = serial_ret_in;
         serial_clk_out = 1'b0;
         #24;
      end
      serial_data_out = ~serial_data_out; // Released, no longer valid
      load_enable_out = 1'b1;
      #250;
   endtask
   task automatic idle_clocks();
      for (int i = 0; i < 8; i++) begin
         serial_data_out = 1'b1;
         serial_clk_out = 1'b1;
         #24;
         serial_clk_out = 1'b0;
         #24;
      end
   endtask
endmodule // ods_host_model

// ===== dv/test_octal_driver_serial_ctrl_diag.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module test_octal_driver_serial_ctrl_diag;
   logic       clk, rst, cen, standby_n_n, otemp, emerg, ovolt;
   logic       scl, si, le, so_lvl, so_oe, so_pin, short_n, open_n;
   logic [7:0] above, dissip, drv;
   int         num_errors;
   int         cmp_count;
   wire  [9:0] obs = {short_n, open_n, drv};
   assign so_pin = so_oe ? so_lvl : 1'b1; // Pull-up on the pin
   ods_host_model host (.serial_clk_out(scl), .serial_data_out(si),
      .load_enable_out(le), .serial_ret_in(so_pin));
   ods_driver_core dut (.clk_sys_in(clk), .sys_rst_in(rst), .clk_en_in(cen),
      .serial_clk_in(scl), .serial_in(si), .load_enable_in(le),
      .serial_out_out(so_lvl), .serial_out_oe_out(so_oe), .standby_n_in(standby_n_n),
      .out_above_ref_in(above), .overtemp_in(otemp), .emergency_temp_in(emerg),
      .local_dissip_in(dissip), .supply_overvoltage_threshold_in(ovolt),
      .driver_output_out(drv), .short_fault_flag_n_out(short_n),
      .open_load_flag_n_out(open_n));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic results();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Bounded wait covers the 200-cycle blanking time
   task automatic wait_obs(input logic [9:0] exp);
      int n;
      n = 0;
      while (obs !== exp && n < 300) begin
         cyc(1);
         n++;
      end
      chk(obs, exp);
      if (obs !== exp) results();
   endtask
   task automatic sc_write();
      logic [23:0] vals;
      logic [7:0]  st;
      vals = 24'h0F00A5;
      for (int i = 0; i < 3; i++) begin
         host.xfer(vals[8*(2-i) +: 8], st);
         if (i > 0) chk({2'b00, st}, {2'b00, vals[8*(3-i) +: 8]});
         cyc(1);
         above = ~vals[8*(2-i) +: 8];
         wait_obs({2'b11, vals[8*(2-i) +: 8]});
      end
   endtask
   task automatic sc_fault();
      logic [7:0] st;
      cyc(1);
      above = 8'h59;
      wait_obs({2'b00, 8'hA5});
      host.xfer(8'hA5, st);
      chk({2'b00, st}, {2'b00, 8'hA6});
      chk(obs, {2'b10, 8'hA5});
      wait_obs({2'b00, 8'hA5});
   endtask
   task automatic sc_protect();
      for (int k = 0; k < 3; k++) begin
         cyc(1);
         {otemp, dissip[3], ovolt} = 3'b100 >> k;
         wait_obs({2'b00, 8'hA4});
         cyc(1);
         {otemp, dissip[3], ovolt} = 3'b000;
         wait_obs({2'b00, 8'hA5});
      end
      cyc(1);
      {emerg, otemp} = 2'b11;
      wait_obs({2'b00, 8'h00});
      emerg = 1'b0;
      cyc(20);
      chk(obs, {2'b00, 8'h00});
      otemp = 1'b0;
      wait_obs({2'b00, 8'hA5});
   endtask
   task automatic sc_idle();
      host.idle_clocks();
      chk({9'h000, so_pin}, 10'h001);
      chk(obs, {2'b00, 8'hA5});
   endtask
   task automatic sc_standby();
      cyc(1);
      standby_n_n = 1'b0;
      wait_obs({2'b10, 8'h00});
      cyc(1);
      standby_n_n = 1'b1;
      cyc(10);
      chk(obs, {2'b10, 8'h00});
   endtask
   task automatic sc_freeze();
      cyc(1);
      cen = 1'b0;
      above = 8'hFF;
      cyc(10);
      chk(obs, {2'b10, 8'h00});
      cen = 1'b1;
      wait_obs({2'b11, 8'h00});
   endtask
   initial begin
      num_errors = 0;
      cmp_count = 0;
      rst = 1'b1;
      {cen, standby_n_n, otemp, emerg, ovolt} = 5'b11000;
      above = 8'h00;
      dissip = 8'h00;
      cyc(5);
      rst = 1'b0;
      wait_obs({2'b10, 8'h00});
      sc_write();
      sc_fault();
      sc_protect();
      sc_idle();
      sc_standby();
      sc_freeze();
      results();
   end
endmodule // test_octal_driver_serial_ctrl_diag
